// ---- pco_clk_sink.sv ----
`timescale 1ns/10ps
// Receiver of the peripheral clock: counts rises and their spacing
module pco_clk_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   input wire logic pin_oe_n,
   output logic [15:0] rises,
   output logic [7:0] gap
);
   logic last_r; // Level seen one cycle ago
   logic [7:0] cnt_r; // Cycles since the last rise
   ////////////////////////////////////////////////////////////////////////////////
   // A pin the device does not drive carries no clock, so it is ignored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_r <= 1'b0;
         rises <= 16'h0000;
         gap <= 8'h00;
         cnt_r <= 8'h00;
      end else if (pin_oe_n == 1'b0) begin
         last_r <= pin;
         cnt_r <= cnt_r + 8'h01;
         // Rising edge: record spacing
         if (pin && !last_r) begin
            rises <= rises + 16'h0001;
            gap <= cnt_r + 8'h01;
            cnt_r <= 8'h00;
         end
      end else begin
         last_r <= 1'b0;
         cnt_r <= 8'h00;
      end
   end
endmodule : pco_clk_sink

// ---- pco_divider.sv ----
`timescale 1ns/10ps
// Free-running divider giving the shared count for the derived rates
module pco_divider (
   input wire logic clk,
   input wire logic rst,
   output logic [5:0] count
);
   ////////////////////////////////////////////////////////////////////////
   // Never reset except at power-on, so phase is shared by all users
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 6'h00;
      end else begin
         count <= count + 6'h01;
      end
   end
endmodule : pco_divider

// ---- pco_pkg.sv ----
// Overview of operation
// - Clock output follows internal system clock
// - Pin carries clock only while enabled
// - Enable bit starts and stops clock
// - Source code selects sys, /4, /8, timer/2
// - Sleep stops clock output regardless
// - Modes 000-100 select SPI master clocks
// - Disabled serial lines float, idle
// - Serial enable rise leaves SPI undefined
// - Serial enable needs configuration option
// - Bit zero reads zero, ignores writes
package pco_pkg;
   // Register byte address
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   // Field positions of the control register
   localparam int MODE_LSB = 5;
   localparam int CKEN_BIT = 4;
   localparam int SRC_LSB = 2;
   localparam int SIEN_BIT = 1;
   // Reset value: mode 111, all else zero
   localparam logic [7:0] CTRL_RESET = 8'hE0;
   // Writable bits; bit 0 unimplemented
   localparam logic [7:0] CTRL_WMASK = 8'hFE;
   // Clock output source codes
   typedef enum logic [1:0] {
      SRC_SYS = 2'b00,
      SRC_DIV4 = 2'b01,
      SRC_DIV8 = 2'b10,
      SRC_TMR = 2'b11
   } pco_src_type;
   // Serial mode codes
   localparam logic [2:0] MODE_SPI_SLAVE = 3'b101;
   localparam logic [2:0] MODE_I2C_SLAVE = 3'b110;
   localparam logic [2:0] MODE_UNUSED = 3'b111;
   // AHB transfer type and size
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage : pco_pkg

// ---- pco_top.sv ----
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
// Peripheral clock output and serial mode control register
module pco_top (
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // System inputs
   input wire logic sleep_mode,
   input wire logic serial_cfg_option,
   input wire logic timer0_out,
   input wire logic sub_clock_en,
   input wire logic port_b_bit4,
   input wire logic port_b_bit4_oe_n,
   // Pin outputs
   output logic periph_clock_out,
   output logic periph_pin_oe_n,
   // Serial block controls
   output logic serial_active,
   output logic [2:0] serial_mode,
   output logic serial_master_tick,
   output logic serial_lines_float,
   output logic serial_regs_invalidate
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] ctrl_r; // Control register
   logic wr_pend_r; // Write data phase pending
   logic [31:0] rd_data_nxt; // Read mux
   logic [5:0] div_count; // Free counter
   logic tmr_d_r; // Timer output delayed
   logic tmr_half_r; // Timer 0 output halved
   logic pck_r; // Selected clock level
   logic pck_nxt;
   logic [1:0] src_live_r; // Source actually used
   logic pin_clock_r; // Pin in clock mode
   logic pin_level_r; // Pin level
   logic oe_n_r;
   logic act_r;
   logic [2:0] mode_r;
   logic tick_r;
   logic float_r;
   logic inval_r;
   logic sien_d_r; // Effective serial enable, delayed
   logic sien_eff; // Serial enable gated by option
   logic tick_nxt;
   logic pck_run; // Clock allowed to run

   // Decode of a valid access in the address phase
   function automatic logic acc_ok(input logic sel, input logic [1:0] tr, input logic rdy);
      acc_ok = sel && rdy && (tr == pco_pkg::HTRANS_NONSEQ);
   endfunction : acc_ok

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Write capture in the address phase, commit in the data phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
      end else if (hready) begin
         wr_pend_r <= acc_ok(hsel, htrans, hready) && hwrite &&
            (haddr[7:0] == pco_pkg::CTRL_ADDR) && (haddr[31:8] == 24'h0000_00);
      end
   end

   // Control register; bit 0 never stored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= pco_pkg::CTRL_RESET;
      end else if (wr_pend_r) begin
         ctrl_r <= hwdata[7:0] & pco_pkg::CTRL_WMASK;
      end
   end

   // A committed write keeps only the implemented bits
   AST_WRITE_MASK: assert property (@(posedge clk) disable iff (rst)
      wr_pend_r |=> ctrl_r == ($past(hwdata[7:0]) & pco_pkg::CTRL_WMASK))
      else $error("write not stored");

   // Read data; unmapped addresses read zero
   always_comb begin
      rd_data_nxt = 32'h0000_0000;
      if (haddr == {24'h0000_00, pco_pkg::CTRL_ADDR}) begin
         rd_data_nxt = {24'h0000_00, ctrl_r & pco_pkg::CTRL_WMASK};
      end
   end

   // Read data registered for the data phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && acc_ok(hsel, htrans, hready) && !hwrite) begin
         hrdata <= rd_data_nxt;
      end
   end

   // Read data never shows bit 0 or the upper bytes
   AST_READ_ZERO: assert property (@(posedge clk) disable iff (rst)
      acc_ok(hsel, htrans, hready) && !hwrite |=> hrdata[31:8] == 24'h0000_00 && !hrdata[0])
      else $error("unimplemented bits read");

   ////////////////////////////////////////////////////////////////////////
   // Shared free-running divider
   pco_divider u_div (
      .clk(clk),
      .rst(rst),
      .count(div_count)
   );

   // Timer 0 output halved on each rising edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tmr_d_r <= 1'b0;
         tmr_half_r <= 1'b0;
      end else begin
         tmr_d_r <= timer0_out;
         if (timer0_out && !tmr_d_r) begin
            tmr_half_r <= !tmr_half_r;
         end
      end
   end

   // Every timer rise flips the half-rate level
   AST_TMR_HALF: assert property (@(posedge clk) disable iff (rst)
      timer0_out && !tmr_d_r |=> tmr_half_r != $past(tmr_half_r))
      else $error("timer half missed");

   ////////////////////////////////////////////////////////////////////////
   // Source switch only while the output is low, avoiding runt pulses
   assign pck_run = ctrl_r[pco_pkg::CKEN_BIT] && !sleep_mode;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_live_r <= pco_pkg::SRC_SYS;
      end else if (!pck_r) begin
         src_live_r <= ctrl_r[pco_pkg::SRC_LSB +: 2];
      end
   end

   // A switch while high could cut the pulse short
   AST_SRC_HOLD: assert property (@(posedge clk) disable iff (rst)
      pck_r |=> src_live_r == $past(src_live_r))
      else $error("source switched while high");

   // Selected level; undivided rate shown as a per-cycle toggle
   always_comb begin
      unique case (pco_pkg::pco_src_type'(src_live_r))
         pco_pkg::SRC_SYS: pck_nxt = !pck_r;
         pco_pkg::SRC_DIV4: pck_nxt = div_count[1];
         pco_pkg::SRC_DIV8: pck_nxt = div_count[2];
         pco_pkg::SRC_TMR: pck_nxt = tmr_half_r;
      endcase
   end

   // Clock level, parked low when stopped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pck_r <= 1'b0;
      end else if (!pck_run) begin
         pck_r <= 1'b0;
      end else begin
         pck_r <= pck_nxt;
      end
   end

   // Undivided source flips every cycle while running
   AST_SYS_TOGGLE: assert property (@(posedge clk) disable iff (rst)
      pck_run && src_live_r == pco_pkg::SRC_SYS |=> pck_r != $past(pck_r))
      else $error("sys source not toggling");

   // Quarter rate follows counter bit 1
   AST_DIV4_LEVEL: assert property (@(posedge clk) disable iff (rst)
      pck_run && src_live_r == pco_pkg::SRC_DIV4 |=> pck_r == $past(div_count[1]))
      else $error("div4 level wrong");

   // Eighth rate follows counter bit 2
   AST_DIV8_LEVEL: assert property (@(posedge clk) disable iff (rst)
      pck_run && src_live_r == pco_pkg::SRC_DIV8 |=> pck_r == $past(div_count[2]))
      else $error("div8 level wrong");

   // Timer source follows the halved timer level
   AST_TMR_LEVEL: assert property (@(posedge clk) disable iff (rst)
      pck_run && src_live_r == pco_pkg::SRC_TMR |=> pck_r == $past(tmr_half_r))
      else $error("timer level wrong");

   // Pin function mux: clock only while enabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_clock_r <= 1'b0;
         pin_level_r <= 1'b0;
         oe_n_r <= 1'b1;
      end else begin
         pin_clock_r <= ctrl_r[pco_pkg::CKEN_BIT];
         if (ctrl_r[pco_pkg::CKEN_BIT]) begin
            pin_level_r <= pck_r && pck_run;
            oe_n_r <= 1'b0;
         end else begin
            pin_level_r <= port_b_bit4;
            oe_n_r <= port_b_bit4_oe_n;
         end
      end
   end

   assign periph_clock_out = pin_level_r;
   assign periph_pin_oe_n = oe_n_r;

   // Clock function always drives the pin
   AST_PIN_DRIVE: assert property (@(posedge clk) disable iff (rst)
      pin_clock_r |-> !periph_pin_oe_n)
      else $error("clock pin not driven");

   // Enabled pin shows the running level one cycle on
   AST_PIN_CLOCK: assert property (@(posedge clk) disable iff (rst)
      ctrl_r[pco_pkg::CKEN_BIT] |=> periph_clock_out == ($past(pck_r) && $past(pck_run)))
      else $error("pin not following clock");

   ////////////////////////////////////////////////////////////////////////
   // Serial enable effective only with the option set
   assign sien_eff = ctrl_r[pco_pkg::SIEN_BIT] && serial_cfg_option;

   // Master serial clock tick per mode
   always_comb begin
      tick_nxt = 1'b0;
      unique case (ctrl_r[pco_pkg::MODE_LSB +: 3])
         3'b000: tick_nxt = (div_count[1:0] == 2'b11);
         3'b001: tick_nxt = (div_count[3:0] == 4'hF);
         3'b010: tick_nxt = (div_count == 6'h3F);
         3'b011: tick_nxt = sub_clock_en;
         3'b100: tick_nxt = timer0_out && !tmr_d_r && tmr_half_r;
         pco_pkg::MODE_SPI_SLAVE: tick_nxt = 1'b0;
         pco_pkg::MODE_I2C_SLAVE: tick_nxt = 1'b0;
         pco_pkg::MODE_UNUSED: tick_nxt = 1'b0;
      endcase
   end

   // Fastest master rate ticks on counter wrap of two bits
   AST_TICK_DIV4: assert property (@(posedge clk) disable iff (rst)
      sien_eff && ctrl_r[pco_pkg::MODE_LSB +: 3] == 3'b000 &&
      div_count[1:0] == 2'b11 |=> serial_master_tick) else $error("div4 tick missing");

   // Slowest divided rate ticks on full counter wrap
   AST_TICK_DIV64: assert property (@(posedge clk) disable iff (rst)
      sien_eff && ctrl_r[pco_pkg::MODE_LSB +: 3] == 3'b010 &&
      div_count == 6'h3F |=> serial_master_tick) else $error("div64 tick missing");

   // Sub-clock mode passes the sub-clock enable through
   AST_TICK_SUB: assert property (@(posedge clk) disable iff (rst)
      sien_eff && ctrl_r[pco_pkg::MODE_LSB +: 3] == 3'b011 |=>
      serial_master_tick == $past(sub_clock_en)) else $error("sub tick wrong");

   // Bus slave and unused modes make no master clock
   AST_TICK_IDLE: assert property (@(posedge clk) disable iff (rst)
      ctrl_r[pco_pkg::MODE_LSB +: 3] == pco_pkg::MODE_I2C_SLAVE ||
      ctrl_r[pco_pkg::MODE_LSB +: 3] == pco_pkg::MODE_UNUSED |=> !serial_master_tick)
      else $error("idle mode ticks");

   // Serial control outputs, all registered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         act_r <= 1'b0;
         mode_r <= pco_pkg::MODE_UNUSED;
         tick_r <= 1'b0;
         float_r <= 1'b1;
         inval_r <= 1'b0;
         sien_d_r <= 1'b0;
      end else begin
         sien_d_r <= sien_eff;
         mode_r <= ctrl_r[pco_pkg::MODE_LSB +: 3];
         // Unused mode leaves the block idle
         act_r <= sien_eff && (ctrl_r[pco_pkg::MODE_LSB +: 3] != pco_pkg::MODE_UNUSED);
         float_r <= !sien_eff;
         tick_r <= sien_eff && tick_nxt;
         inval_r <= sien_eff && !sien_d_r;
      end
   end

   assign serial_active = act_r;
   assign serial_mode = mode_r;
   assign serial_master_tick = tick_r;
   assign serial_lines_float = float_r;
   assign serial_regs_invalidate = inval_r;

   // Serial block sees the mode field one cycle late
   AST_MODE_COPY: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> serial_mode == $past(ctrl_r[pco_pkg::MODE_LSB +: 3]))
      else $error("mode not copied");

   // Unused code never activates the block
   AST_UNUSED_IDLE: assert property (@(posedge clk) disable iff (rst)
      ctrl_r[pco_pkg::MODE_LSB +: 3] == pco_pkg::MODE_UNUSED |=> !serial_active)
      else $error("unused mode active");

   // Effective enable with a real mode activates the block
   AST_ACTIVE: assert property (@(posedge clk) disable iff (rst)
      sien_eff && ctrl_r[pco_pkg::MODE_LSB +: 3] != pco_pkg::MODE_UNUSED |=> serial_active)
      else $error("serial not active");

   // Enabled interface drives its lines
   AST_FLOAT_ON: assert property (@(posedge clk) disable iff (rst)
      sien_eff |=> !serial_lines_float)
      else $error("lines float while enabled");

   // Invalidate lasts exactly one cycle
   AST_INVAL_PULSE: assert property (@(posedge clk) disable iff (rst)
      serial_regs_invalidate |=> !serial_regs_invalidate)
      else $error("invalidate too long");

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_BIT0_ZERO: assert property (@(posedge clk) disable iff (rst)
      !ctrl_r[0]) else $error("bit 0 stored");
   AST_STOP_EN: assert property (@(posedge clk) disable iff (rst)
      !ctrl_r[pco_pkg::CKEN_BIT] |=> !pck_r) else $error("clock runs while off");
   AST_SLEEP: assert property (@(posedge clk) disable iff (rst)
      sleep_mode |=> !pck_r) else $error("clock runs in sleep");
   AST_PIN_PORT: assert property (@(posedge clk) disable iff (rst)
      !ctrl_r[pco_pkg::CKEN_BIT] |=> periph_clock_out == $past(port_b_bit4))
      else $error("pin not port");
   AST_FLOAT: assert property (@(posedge clk) disable iff (rst)
      !sien_eff |=> serial_lines_float && !serial_master_tick)
      else $error("serial not idle");
   AST_OPTION: assert property (@(posedge clk) disable iff (rst)
      !serial_cfg_option |=> !serial_active) else $error("option ignored");
   AST_SLAVE_NOCLK: assert property (@(posedge clk) disable iff (rst)
      ctrl_r[pco_pkg::MODE_LSB +: 3] == pco_pkg::MODE_SPI_SLAVE |=> !serial_master_tick)
      else $error("slave clock made");
   AST_INVAL: assert property (@(posedge clk) disable iff (rst)
      $rose(sien_eff) |=> serial_regs_invalidate ##1 !serial_regs_invalidate)
      else $error("no invalidate pulse");
   AST_DIV4: assert property (@(posedge clk) disable iff (rst)
      (pck_run && src_live_r == 2'b01) [*4] |=> pck_r == div_count[1] ^ 1'b0 ||
      pck_r != $past(pck_r, 2)) else $error("div4 stuck");
   COV_DIV8: cover property (@(posedge clk) pck_run && src_live_r == 2'b10 && pck_r);
   COV_TMR: cover property (@(posedge clk) pck_run && src_live_r == 2'b11 && pck_r);
   COV_SPI: cover property (@(posedge clk) serial_master_tick);
   COV_SLEEP: cover property (@(posedge clk) sleep_mode && ctrl_r[pco_pkg::CKEN_BIT]);
   COV_INVAL: cover property (@(posedge clk) serial_regs_invalidate);
endmodule : pco_top

// ---- tb.sv ----
`timescale 1ns/10ps
// Bench for the clock output and serial mode register
module tb;
   localparam logic [31:0] A = 32'(pco_pkg::CTRL_ADDR); // Control word address
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
   logic sleep_mode = 1'b0, serial_cfg_option = 1'b0, timer0_out = 1'b0, sub_clock_en = 1'b0;
   logic port_b_bit4 = 1'b0, port_b_bit4_oe_n = 1'b1, periph_clock_out, periph_pin_oe_n;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, w;
   logic [31:0] lfsr = 32'h0571_0611; // Fixed seed
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b000, serial_mode, tcnt = 3'b000;
   logic hreadyout, hresp, serial_active, serial_master_tick, serial_lines_float;
   logic serial_regs_invalidate;
   logic [15:0] rises, r0, ticks = 0, invs = 0;
   logic [15:0] subs = 16'h0000, s0; // Sub-clock pulses seen, lined up with ticks
   logic sub_d = 1'b0;
   logic [7:0] gap;
   int bad_count = 0, compares = 0, g;

   assign hready = hreadyout; // Single slave
   always #5 clk = ~clk;

   pco_top i_pco_top (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .sleep_mode, .serial_cfg_option, .timer0_out, .sub_clock_en,
      .port_b_bit4, .port_b_bit4_oe_n, .periph_clock_out, .periph_pin_oe_n, .serial_active,
      .serial_mode, .serial_master_tick, .serial_lines_float, .serial_regs_invalidate);
   pco_clk_sink i_pco_clk_sink (.clk, .rst, .pin(periph_clock_out), .pin_oe_n(periph_pin_oe_n),
      .rises, .gap);

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] next_rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rnd
   // Control word from its fields
   function automatic logic [31:0] cw(input logic [2:0] m, input logic e, input logic [1:0] s,
      input logic v);
      return 32'(m) << pco_pkg::MODE_LSB | 32'(e) << pco_pkg::CKEN_BIT
         | 32'(s) << pco_pkg::SRC_LSB | 32'(v) << pco_pkg::SIEN_BIT;
   endfunction : cw
   // Timer period is 8 cycles, so its half is a 16-cycle clock
   function automatic int exp_gap(input int s);
      return (s == 0) ? 2 : (s == 1) ? 4 : (s == 2) ? 8 : 16;
   endfunction : exp_gap
   function automatic int exp_tick(input int m);
      return (m == 0) ? 4 : (m == 2) ? 64 : 16;
   endfunction : exp_tick

   // Free timer, random sub-clock, event counters
   always @(posedge clk) begin
      lfsr <= next_rnd(lfsr);
      sub_clock_en <= lfsr[3];
      tcnt <= tcnt + 3'b001;
      timer0_out <= tcnt[2];
      ticks <= ticks + 16'(serial_master_tick);
      invs <= invs + 16'(serial_regs_invalidate);
      sub_d <= sub_clock_en;
      subs <= subs + 16'(sub_d);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One single transfer; entered just after a rising edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      hsize <= pco_pkg::HSIZE_WORD;
      htrans <= pco_pkg::HTRANS_NONSEQ;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wr ? d : 32'h0000_0000;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : ahb
   task automatic tick_gap(output int n);
      for (int i = 0; i < 300 && serial_master_tick !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
      n = 1;
      while (serial_master_tick !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask : tick_gap
   task automatic report_and_stop;
      if (bad_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   // Watchdog: whole run needs under two thousand cycles
   initial begin
      #100_000;
      bad_count++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      ahb(0, A, 0);
      check("ctrl reset", rd, 32'(pco_pkg::CTRL_RESET));
      ahb(0, 32'h0000_0010, 0);
      check("unmapped", rd, 0);
      check("okay response", hresp, 0);
      // Random words with bit 0 forced high
      for (int i = 0; i < 6; i++) begin
         w = lfsr | 32'h0000_0001;
         ahb(1, A, w);
         ahb(0, A, 0);
         check("ctrl word", rd, 32'(w[7:0] & pco_pkg::CTRL_WMASK));
      end
      // Every output source, timer last
      for (int s = 0; s < 4; s++) begin
         ahb(1, A, cw(3'b111, 1'b1, s[1:0], 1'b0));
         repeat (60) @(posedge clk);
         check("pin enable", periph_pin_oe_n, 0);
         check("clock gap", gap, exp_gap(s));
      end
      // Sleep halts the clock, wake restarts it
      sleep_mode <= 1'b1;
      repeat (4) @(posedge clk);
      r0 = rises;
      repeat (40) @(posedge clk);
      check("rises in sleep", rises, r0);
      check("pin in sleep", periph_clock_out, 0);
      sleep_mode <= 1'b0;
      repeat (60) @(posedge clk);
      check("gap after wake", gap, 16);
      // Disabled: pin follows the port
      ahb(1, A, cw(3'b111, 1'b0, 2'b01, 1'b0));
      for (int i = 0; i < 4; i++) begin
         port_b_bit4 <= lfsr[0];
         port_b_bit4_oe_n <= lfsr[1];
         repeat (4) @(posedge clk);
         check("port level", periph_clock_out, port_b_bit4);
         check("port enable", periph_pin_oe_n, port_b_bit4_oe_n);
      end
      // Serial enable without, then with, the option
      ahb(1, A, cw(3'b000, 1'b0, 2'b00, 1'b1));
      repeat (4) @(posedge clk);
      check("active no option", serial_active, 0);
      check("float no option", serial_lines_float, 1);
      serial_cfg_option <= 1'b1;
      repeat (4) @(posedge clk);
      check("active", serial_active, 1);
      check("float", serial_lines_float, 0);
      check("invalidate count", invs, 1);
      // Master rates, slave modes and the unused code
      for (int m = 0; m < 8; m++) begin
         ahb(1, A, cw(m[2:0], 1'b0, 2'b00, 1'b1));
         repeat (70) @(posedge clk);
         check("mode copy", serial_mode, m);
         check("mode active", serial_active, m != 7);
         if (m == 3) begin
            r0 = ticks;
            s0 = subs;
            repeat (100) @(posedge clk);
            check("sub ticks", ticks - r0, subs - s0);
         end else if (m < 5) begin
            tick_gap(g);
            check("tick gap", g, exp_tick(m));
         end else begin
            r0 = ticks;
            repeat (100) @(posedge clk);
            check("no master tick", ticks, r0);
         end
      end
      report_and_stop();
   end
endmodule : tb
